// [audio_dac_clock_tree_pll.sv]
// Audio DAC clock tree: root select, PLL model, cascaded dividers.
// Assumes pin inputs synchronous to clock; clocks are carried as
// one-cycle edge events (every edge of a pin clock is one event).
//
// Notes on behaviour
// R1: Core root picks master, bit clock, I/O pin or PLL by two bits.
// R2: Modulator clock is root divided by first then second 7-bit divider.
// R3: Sample rate is modulator clock over 10-bit split oversampling ratio.
// R4: Host powers both dividers before powering the DAC channel.
// R5: DAC power-down runs a shutdown sequence shown by two status flags.
// R6: Host keeps dividers up until flags show down, second off first.
// R7: Host powers down a parent divider only after all its children.
// R8: Bit clock output is its source divided by 1 to 128.
// R9: Bit clock divider source is processing or modulator clock.
// R10: I/O pin can carry a general clock divided by 1 to 128.
// R11: General clock source is chosen by a three-bit selector.
// R12: PLL control top bit powers the PLL on or off.
// R13: PLL control holds pre-divider 1..8 and multiplier 1..16, both 1.
// R14: PLL integer multiplier is six bits, 1 to 63, reset 4.
// R15: Fraction is 14 bits, 0..9999, split upper six and lower eight.
// R16: Fraction takes effect only when the lower byte write completes.
// R17: PLL output is reference times R times J.D over P.
// R18: Host keeps PLL ranges for zero fraction, multiplier product 4..259.
// R19: Host keeps PLL ranges for nonzero fraction with R at one.
// R20: PLL output appears about 10 ms after power-up.
// R21: Host powers the PLL first and last when it feeds the root.
// R22: PLL runs without the DAC and can feed the I/O pin clock.
// R23: A divider with its power bit clear stops all clocks below it.
`default_nettype none
module audio_dac_clock_tree_pll #(
   parameter int LOCK_CYCLES = clock_tree_pkg::PLL_LOCK_CYCLES
) (
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output var  logic [7:0] reg_rdata,
   input  wire logic       mclk_in,
   input  wire logic       bclk_in,
   output var  logic       bclk_out,
   output var  logic       bclk_oe,
   input  wire logic       gpio_in,
   output var  logic       gpio_out,
   output var  logic       gpio_oe,
   input  wire logic       dac_power,
   output var  logic       modulator_clock,
   output var  logic       sample_rate,
   output var  logic       pll_ready
);
   import clock_tree_pkg::*;

   // Also ends a count left above a newly lowered limit; zero means 1024
   function automatic logic last_count(input logic [9:0] cnt,
      input logic [9:0] lim);
      return cnt >= lim - 10'h001;
   endfunction

   function automatic logic [9:0] wrap_count(input logic [9:0] cnt,
      input logic [9:0] lim, input logic go);
      if (!go)
         return cnt;
      if (last_count(cnt, lim))
         return 10'h000;
      return cnt + 10'h001;
   endfunction

   logic [7:0] source_sel, pll_ctrl, pll_j, frac_hi, frac_lo;
   logic [7:0] first_div, second_div, osr_hi, osr_lo;
   logic [7:0] gp_source, gp_div, bclk_dir, bdiv_src, bclk_div, gpio_ctrl;
   logic [13:0] frac_active;
   logic mclk_q, bclk_q, gpio_q;
   logic [31:0] lock_count;
   logic pll_locked;
   logic [27:0] pll_acc;
   logic [9:0] first_cnt, second_cnt, osr_cnt, bdiv_cnt, gdiv_cnt;
   logic dac_up, shutting;
   logic [6:0] shut_cnt;

   // Pin edge events
   wire mclk_edge = mclk_in ^ mclk_q;
   wire bclk_edge = bclk_in ^ bclk_q;
   wire gpio_edge = gpio_in ^ gpio_q;

   // PLL model: fractional accumulator on the reference events
   wire        pll_on = pll_ctrl[POWER_BIT];
   wire [2:0]  pre_code = pll_ctrl[6:4];
   wire [3:0]  r_code = pll_ctrl[3:0];
   wire [3:0]  pll_p = (pre_code == 3'h0) ? 4'h8 : {1'b0, pre_code};
   wire [4:0]  pll_r = (r_code == 4'h0) ? 5'h10 : {1'b0, r_code};
   wire [5:0]  pll_jv = pll_j[5:0];
   wire [19:0] jd = 20'(pll_jv * FRAC_SCALE) + 20'(frac_active);
   wire [27:0] pll_inc = 28'(jd * pll_r);
   wire [27:0] pll_thr = 28'(pll_p * FRAC_SCALE);
   wire [1:0]  ref_sel = source_sel[3:2];
   wire ref_edge = (ref_sel == 2'h1) ? bclk_edge :
                   (ref_sel == 2'h2) ? gpio_edge : mclk_edge;
   wire pll_fire = pll_locked && (pll_acc >= pll_thr);
   wire [28:0] acc_sum = 29'(pll_acc) + (ref_edge ? 29'(pll_inc) : 29'h0)
                         - (pll_fire ? 29'(pll_thr) : 29'h0);
   wire [27:0] next_acc = acc_sum[28] ? 28'hfff_ffff : acc_sum[27:0];
   wire pll_edge = pll_fire; // R17

   // Root select
   root_source_t root_sel;
   assign root_sel = root_source_t'(source_sel[1:0]);
   wire root_edge = (root_sel == SRC_MCLK) ? mclk_edge :
                    (root_sel == SRC_BCLK) ? bclk_edge :
                    (root_sel == SRC_GPIO) ? gpio_edge : pll_edge; // R1

   // Divider chain; a powered-off divider passes no events
   wire first_on  = first_div[POWER_BIT];
   wire second_on = second_div[POWER_BIT];
   wire [9:0] first_lim  = {2'b00, first_div[6:0] == 7'h0, first_div[6:0]};
   wire [9:0] second_lim = {2'b00, second_div[6:0] == 7'h0,
                            second_div[6:0]};
   wire [9:0] osr_lim = {osr_hi[1:0], osr_lo};
   wire [9:0] bdiv_lim = {2'b00, bclk_div[6:0] == 7'h0, bclk_div[6:0]};
   wire [9:0] gdiv_lim = {2'b00, gp_div[6:0] == 7'h0, gp_div[6:0]};
   wire first_go  = first_on && root_edge; // R23
   wire proc_edge = first_go && last_count(first_cnt, first_lim); // R2
   wire second_go = second_on && proc_edge; // R23
   wire mod_edge  = second_go && last_count(second_cnt, second_lim); // R2
   // Zero ratio code wraps the 10-bit counter, giving 1024
   wire sample_edge = mod_edge && last_count(osr_cnt, osr_lim); // R3

   wire bdiv_src_edge = (bdiv_src[1:0] == 2'h1) ? mod_edge : proc_edge; // R9
   wire bdiv_edge = bdiv_src_edge && last_count(bdiv_cnt, bdiv_lim); // R8
   wire gp_src_edge = (gp_source[2:0] == 3'h0) ? mclk_edge :
                      (gp_source[2:0] == 3'h1) ? bclk_edge :
                      (gp_source[2:0] == 3'h2) ? root_edge :
                      (gp_source[2:0] == 3'h3) ? pll_edge :
                      (gp_source[2:0] == 3'h4) ? proc_edge :
                      (gp_source[2:0] == 3'h5) ? mod_edge :
                      (gp_source[2:0] == 3'h6) ? bdiv_src_edge :
                      sample_edge; // R11 R22
   wire gdiv_edge = gp_src_edge && last_count(gdiv_cnt, gdiv_lim); // R10

   // Shutdown advances only on modulator events, so dividers must stay up
   wire shut_done = shutting && mod_edge &&
                    (shut_cnt == 7'(SHUTDOWN_MOD_EDGES - 1)); // R5 R6
   wire [7:0] status_word = {dac_up, 3'b000, dac_up, 3'b000};

   wire [7:0] read_word =
      (reg_addr == OFS_SOURCE)     ? source_sel :
      (reg_addr == OFS_PLL_CTRL)   ? pll_ctrl :
      (reg_addr == OFS_PLL_J)      ? {2'b00, pll_j[5:0]} :
      (reg_addr == OFS_FRAC_HI)    ? {2'b00, frac_hi[5:0]} :
      (reg_addr == OFS_FRAC_LO)    ? frac_lo :
      (reg_addr == OFS_FIRST_DIV)  ? first_div :
      (reg_addr == OFS_SECOND_DIV) ? second_div :
      (reg_addr == OFS_OSR_HI)     ? {6'h00, osr_hi[1:0]} :
      (reg_addr == OFS_OSR_LO)     ? osr_lo :
      (reg_addr == OFS_GP_SOURCE)  ? {5'h00, gp_source[2:0]} :
      (reg_addr == OFS_GP_DIV)     ? gp_div :
      (reg_addr == OFS_BCLK_DIR)   ? bclk_dir :
      (reg_addr == OFS_BDIV_SRC)   ? {6'h00, bdiv_src[1:0]} :
      (reg_addr == OFS_BCLK_DIV)   ? bclk_div :
      (reg_addr == OFS_STATUS)     ? status_word :
      (reg_addr == OFS_GPIO_CTRL)  ? gpio_ctrl : 8'h00;

   wire wr_frac_lo = reg_write && (reg_addr == OFS_FRAC_LO);

   always_ff @(posedge clock) begin
      if (reset) begin
         source_sel <= RST_SOURCE;
         pll_ctrl   <= RST_PLL_CTRL; // R13
         pll_j      <= RST_PLL_J; // R14
         frac_hi    <= RST_ZERO;
         frac_lo    <= RST_ZERO;
         first_div  <= RST_DIV;
         second_div <= RST_DIV;
         osr_hi     <= RST_ZERO;
         osr_lo     <= RST_OSR_LO;
         gp_source  <= RST_ZERO;
         gp_div     <= RST_DIV;
         bclk_dir   <= RST_ZERO;
         bdiv_src   <= RST_ZERO;
         bclk_div   <= RST_DIV;
         gpio_ctrl  <= RST_ZERO;
      end else if (reg_write) begin
         if (reg_addr == OFS_SOURCE) begin
            source_sel <= reg_wdata;
         end else if (reg_addr == OFS_PLL_CTRL) begin
            pll_ctrl <= reg_wdata;
         end else if (reg_addr == OFS_PLL_J) begin
            pll_j <= reg_wdata;
         end else if (reg_addr == OFS_FRAC_HI) begin
            frac_hi <= reg_wdata;
         end else if (reg_addr == OFS_FRAC_LO) begin
            frac_lo <= reg_wdata;
         end else if (reg_addr == OFS_FIRST_DIV) begin
            first_div <= reg_wdata;
         end else if (reg_addr == OFS_SECOND_DIV) begin
            second_div <= reg_wdata;
         end else if (reg_addr == OFS_OSR_HI) begin
            osr_hi <= reg_wdata;
         end else if (reg_addr == OFS_OSR_LO) begin
            osr_lo <= reg_wdata;
         end else if (reg_addr == OFS_GP_SOURCE) begin
            gp_source <= reg_wdata;
         end else if (reg_addr == OFS_GP_DIV) begin
            gp_div <= reg_wdata;
         end else if (reg_addr == OFS_BCLK_DIR) begin
            bclk_dir <= reg_wdata;
         end else if (reg_addr == OFS_BDIV_SRC) begin
            bdiv_src <= reg_wdata;
         end else if (reg_addr == OFS_BCLK_DIV) begin
            bclk_div <= reg_wdata;
         end else if (reg_addr == OFS_GPIO_CTRL) begin
            gpio_ctrl <= reg_wdata;
         end
      end
   end

   // Fraction swaps in whole, so the PLL never sees a half-written value
   always_ff @(posedge clock) begin
      if (reset)
         frac_active <= 14'h0000;
      else if (wr_frac_lo)
         frac_active <= {frac_hi[5:0], reg_wdata}; // R15 R16
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         mclk_q <= 1'b0;
         bclk_q <= 1'b0;
         gpio_q <= 1'b0;
      end else begin
         mclk_q <= mclk_in;
         bclk_q <= bclk_in;
         gpio_q <= gpio_in;
      end
   end

   // Lock wait restarts whenever the PLL is switched off
   always_ff @(posedge clock) begin
      if (reset || !pll_on) begin // R12
         lock_count <= 32'h0000_0000;
         pll_locked <= 1'b0;
         pll_acc    <= 28'h000_0000;
      end else begin
         if (!pll_locked)
            lock_count <= lock_count + 32'h0000_0001;
         if (lock_count == 32'(LOCK_CYCLES - 1))
            pll_locked <= 1'b1; // R20
         pll_acc <= pll_locked ? next_acc : 28'h000_0000;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         first_cnt  <= 10'h000;
         second_cnt <= 10'h000;
         osr_cnt    <= 10'h000;
         bdiv_cnt   <= 10'h000;
         gdiv_cnt   <= 10'h000;
      end else begin
         first_cnt  <= wrap_count(first_cnt, first_lim, first_go);
         second_cnt <= wrap_count(second_cnt, second_lim, second_go);
         osr_cnt    <= wrap_count(osr_cnt, osr_lim, mod_edge);
         bdiv_cnt   <= wrap_count(bdiv_cnt, bdiv_lim, bdiv_src_edge);
         gdiv_cnt   <= wrap_count(gdiv_cnt, gdiv_lim, gp_src_edge);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         dac_up   <= 1'b0;
         shutting <= 1'b0;
         shut_cnt <= 7'h00;
      end else if (dac_power) begin
         dac_up   <= 1'b1; // R4
         shutting <= 1'b0;
         shut_cnt <= 7'h00;
      end else if (dac_up && !shutting) begin
         shutting <= 1'b1; // R5
      end else if (shut_done) begin
         dac_up   <= 1'b0; // R5
         shutting <= 1'b0;
      end else if (shutting && mod_edge) begin
         shut_cnt <= shut_cnt + 7'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         reg_rdata       <= 8'h00;
         bclk_out        <= 1'b0;
         bclk_oe         <= 1'b0;
         gpio_out        <= 1'b0;
         gpio_oe         <= 1'b0;
         modulator_clock <= 1'b0;
         sample_rate     <= 1'b0;
         pll_ready       <= 1'b0;
      end else begin
         if (reg_read)
            reg_rdata <= read_word;
         bclk_oe  <= bclk_dir[BCLK_DIR_BIT]; // R8
         gpio_oe  <= gpio_ctrl[GPIO_CLKOUT_BIT]; // R10
         bclk_out <= bclk_out ^ (bclk_dir[BCLK_DIR_BIT] && bdiv_edge);
         gpio_out <= gpio_out ^ (gpio_ctrl[GPIO_CLKOUT_BIT] && gdiv_edge);
         modulator_clock <= modulator_clock ^ mod_edge;
         sample_rate     <= sample_rate ^ sample_edge;
         pll_ready       <= pll_locked;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (reset);

   a_pll_lock_gate: assert property ($rose(pll_locked) |->
      lock_count == 32'(LOCK_CYCLES)) // R20
      else $error("PLL locked before the full lock wait");
   a_pll_off_gate: assert property (!pll_on |=> !pll_locked) // R12
      else $error("PLL stayed locked while powered off");
   a_frac_commit: assert property (wr_frac_lo |=>
      frac_active == {$past(frac_hi[5:0]), $past(reg_wdata)}) // R16
      else $error("Fraction not applied on lower write");
   a_frac_hold: assert property (!wr_frac_lo |=> $stable(frac_active)) // R16
      else $error("Fraction changed without lower write");
   a_first_gate: assert property (!first_on |-> !proc_edge && !mod_edge) // R23
      else $error("Clock passed a powered-down divider");
   a_root_pick: assert property (root_sel == SRC_MCLK |->
      root_edge == mclk_edge) // R1
      else $error("Root clock not from master pin");
   a_mod_ratio: assert property (first_on && second_on &&
      first_lim == 10'h001 && second_lim == 10'h001 |->
      mod_edge == root_edge) // R2
      else $error("Unity dividers did not pass root");
   a_bclk_toggle: assert property (bclk_dir[BCLK_DIR_BIT] && bdiv_edge |=>
      bclk_out != $past(bclk_out)) // R8
      else $error("Bit clock missed a divided edge");
   a_status_up: assert property (dac_power |=> status_word == 8'h88) // R5
      else $error("Status flags not up with DAC powered");
   a_status_hold: assert property ($fell(dac_power) |->
      dac_up [*2]) // R5 R6
      else $error("Status flags dropped without shutdown");

   c_pll_lock: cover property ($rose(pll_locked));
   c_sample_edge: cover property (sample_edge);
   c_shutdown: cover property (shut_done);
   c_gpio_pll: cover property (gp_source[2:0] == 3'h3 && gdiv_edge);
endmodule // audio_dac_clock_tree_pll
`default_nettype wire

// [audio_dac_clock_tree_pll_bench.sv]
// Self-checking bench for the audio DAC clock tree and PLL.
// Assumes the source model drives the three pin clocks.
`default_nettype none
module audio_dac_clock_tree_pll_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import clock_tree_pkg::*;
   localparam int LOCK = 20;
   localparam int W = 800;
   logic       clock = 1'b0;
   logic       reset = 1'b1;
   logic       reg_write = 1'b0;
   logic       reg_read = 1'b0;
   logic       dac_power = 1'b0;
   logic       rd_seen = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [3:0] hm = 4'h2;
   logic [3:0] hb = 4'h3;
   logic [3:0] hg = 4'h5;
   logic [7:0] q [$];
   int         miscompares = 0;
   int         compares = 0;
   int         seed = 45;
   int         n1;
   int         n2;
   int         n;
   int         hs [3] = '{2, 3, 5};
   int         gc [3] = '{0, 4, 5};
   int         gdv [3];
   logic [7:0] ofs [16] = '{OFS_SOURCE, OFS_PLL_CTRL, OFS_PLL_J, OFS_FRAC_HI,
      OFS_FRAC_LO, OFS_FIRST_DIV, OFS_SECOND_DIV, OFS_OSR_HI, OFS_OSR_LO,
      OFS_GP_SOURCE, OFS_GP_DIV, OFS_BCLK_DIR, OFS_BDIV_SRC, OFS_BCLK_DIV,
      OFS_STATUS, OFS_GPIO_CTRL};
   logic [7:0] rst [16] = '{RST_SOURCE, RST_PLL_CTRL, RST_PLL_J, RST_ZERO,
      RST_ZERO, RST_DIV, RST_DIV, RST_ZERO, RST_OSR_LO, RST_ZERO, RST_DIV,
      RST_ZERO, RST_ZERO, RST_DIV, RST_ZERO, RST_ZERO};
   logic [7:0] rsv_a [4] = '{OFS_PLL_J, OFS_FRAC_HI, OFS_OSR_HI,
      OFS_GP_SOURCE};
   logic [7:0] rsv_e [4] = '{8'h3f, 8'h3f, 8'h03, 8'h07};
   wire  logic [7:0] reg_rdata;
   wire  logic [2:0] pins;
   wire  logic bclk_out, bclk_oe, gpio_out, gpio_oe;
   wire  logic modulator_clock, sample_rate, pll_ready;
   // Pin level is whoever drives it; the device wins when enabled
   wire  logic bclk_pin = bclk_oe ? bclk_out : pins[1];
   wire  logic gpio_pin = gpio_oe ? gpio_out : pins[2];

   audio_dac_clock_tree_pll #(.LOCK_CYCLES(LOCK))
      audio_dac_clock_tree_pll_inst (
      .clock(clock), .reset(reset), .reg_write(reg_write),
      .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .mclk_in(pins[0]), .bclk_in(bclk_pin),
      .bclk_out(bclk_out), .bclk_oe(bclk_oe), .gpio_in(gpio_pin),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .dac_power(dac_power),
      .modulator_clock(modulator_clock), .sample_rate(sample_rate),
      .pll_ready(pll_ready));
   clock_source_model clock_source_model_inst (
      .clock(clock), .half_m(hm), .half_b(hb), .half_g(hg), .pins(pins));

   initial forever #2 clock = ~clock;

   task automatic end_sim;
      repeat (3) @(posedge clock);
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check_byte(input logic [7:0] got, input logic [7:0] e);
      compares++;
      if (got !== e) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, e);
      end
   endtask
   // Counts are windowed, so a phase slip of one toggle is allowed
   task automatic check_near(input int got, input int e);
      compares++;
      if (got < e - 1 || got > e + 1) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      q.push_back(e);
      @(posedge clock);
      reg_read <= 1'b0;
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return modulator_clock;
         1: return sample_rate;
         2: return bclk_out;
         default: return gpio_out;
      endcase
   endfunction
   task automatic count(input int s, input int e);
      int   t;
      logic p;
      t = 0;
      repeat (200) @(posedge clock);
      p = pick(s);
      repeat (W) begin
         @(posedge clock);
         if (pick(s) !== p) t++;
         p = pick(s);
      end
      check_near(t, e);
   endtask

   always @(posedge clock) begin
      if (rd_seen) check_byte(reg_rdata, q.pop_front());
      rd_seen <= reg_read;
   end

   initial begin
      #200000;
      miscompares++;
      end_sim();
   end

   initial begin
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      for (int i = 0; i < 16; i++) rd(ofs[i], rst[i]);
      for (int i = 0; i < 4; i++) begin
         wr(rsv_a[i], 8'hff);
         rd(rsv_a[i], rsv_e[i]);
         wr(rsv_a[i], i == 0 ? RST_PLL_J : RST_ZERO);
      end
      wr(OFS_STATUS, 8'hff);
      rd(OFS_STATUS, 8'h00);
      wr(8'h40, 8'h55);
      rd(8'h40, 8'h00);
      n1 = 1 + {$random(seed)} % 3;
      n2 = 1 + {$random(seed)} % 3;
      gdv = '{10, 10 * n1, 10 * n1 * n2};
      wr(OFS_FIRST_DIV, 8'h80 | 8'(n1));
      wr(OFS_SECOND_DIV, 8'h80 | 8'(n2));
      wr(OFS_OSR_LO, 8'h04);
      count(0, W / (2 * n1 * n2));
      count(1, W / (8 * n1 * n2));
      wr(OFS_FIRST_DIV, 8'(n1));
      count(0, 0);
      wr(OFS_FIRST_DIV, 8'h80 | 8'(n1));
      for (int i = 0; i < 3; i++) begin
         wr(OFS_SOURCE, 8'(i));
         count(0, W / (hs[i] * n1 * n2));
      end
      wr(OFS_SOURCE, 8'h00);
      wr(OFS_BCLK_DIR, 8'h08);
      wr(OFS_BDIV_SRC, 8'h01);
      wr(OFS_BCLK_DIV, 8'h03);
      count(2, W / (6 * n1 * n2));
      check_near(bclk_oe === 1'b1 ? 1 : 0, 1);
      wr(OFS_BDIV_SRC, 8'h00);
      count(2, W / (6 * n1));
      wr(OFS_BCLK_DIR, 8'h00);
      wr(OFS_GPIO_CTRL, 8'h01);
      wr(OFS_GP_DIV, 8'h05);
      for (int i = 0; i < 3; i++) begin
         wr(OFS_GP_SOURCE, 8'(gc[i]));
         count(3, W / gdv[i]);
      end
      @(posedge clock);
      dac_power <= 1'b1;
      rd(OFS_STATUS, 8'h88);
      dac_power <= 1'b0;
      rd(OFS_STATUS, 8'h88);
      repeat (1200) @(posedge clock);
      rd(OFS_STATUS, 8'h00);
      dac_power <= 1'b1;
      repeat (4) @(posedge clock);
      // Second divider dropped just before DAC power-down on purpose: the sequence must stall
      wr(OFS_SECOND_DIV, 8'(n2));
      dac_power <= 1'b0;
      repeat (300) @(posedge clock);
      rd(OFS_STATUS, 8'h88);
      wr(OFS_SECOND_DIV, 8'h80 | 8'(n2));
      repeat (1200) @(posedge clock);
      rd(OFS_STATUS, 8'h00);
      wr(OFS_PLL_J, 8'h01);
      wr(OFS_PLL_CTRL, 8'h84);
      n = 0;
      while (pll_ready !== 1'b1 && n < 100) begin
         @(posedge clock);
         #1;
         n++;
      end
      check_near(n, LOCK + 1);
      wr(OFS_FIRST_DIV, 8'h81);
      wr(OFS_SECOND_DIV, 8'h81);
      wr(OFS_SOURCE, 8'h03);
      count(0, W / 4);
      wr(OFS_PLL_CTRL, 8'h91);
      count(0, W / 2);
      wr(OFS_FRAC_HI, 8'h13);
      count(0, W / 2);
      wr(OFS_FRAC_LO, 8'h88);
      count(0, 3 * W / 4);
      wr(OFS_GP_SOURCE, 8'h03);
      count(3, 3 * W / 20);
      wr(OFS_SECOND_DIV, 8'h01);
      wr(OFS_FIRST_DIV, 8'h01);
      wr(OFS_PLL_CTRL, 8'h11);
      repeat (4) @(posedge clock);
      check_near(pll_ready === 1'b0 ? 1 : 0, 1);
      end_sim();
   end
endmodule // audio_dac_clock_tree_pll_bench
`default_nettype wire

// [clock_source_model.sv]
// Reference clock source: three free-running pin clocks.
// Assumes every half period lasts at least one system clock.
`default_nettype none
module clock_source_model (
   input  wire logic       clock,
   input  wire logic [3:0] half_m,
   input  wire logic [3:0] half_b,
   input  wire logic [3:0] half_g,
   output var  logic [2:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt [3] = '{default: 4'h0};
   wire  logic [3:0] half [3];
   assign half[0] = half_m;
   assign half[1] = half_b;
   assign half[2] = half_g;
   initial pins = 3'b000;
   // Pins move just after the edge, once per clock at most
   always @(posedge clock) begin
      for (int i = 0; i < 3; i++) begin
         if (cnt[i] + 4'h1 >= half[i]) begin
            cnt[i] <= 4'h0;
            pins[i] <= ~pins[i];
         end else begin
            cnt[i] <= cnt[i] + 4'h1;
         end
      end
   end
endmodule // clock_source_model
`default_nettype wire

// [clock_tree_pkg.sv]
// Constants for the audio DAC clock tree: register map, fields, resets.
// Assumes a single 250 MHz system clock and the simple register port.
`default_nettype none
package clock_tree_pkg;
   // Register offsets
   localparam logic [7:0] OFS_SOURCE     = 8'h04;
   localparam logic [7:0] OFS_PLL_CTRL   = 8'h05;
   localparam logic [7:0] OFS_PLL_J      = 8'h06;
   localparam logic [7:0] OFS_FRAC_HI    = 8'h07;
   localparam logic [7:0] OFS_FRAC_LO    = 8'h08;
   localparam logic [7:0] OFS_FIRST_DIV  = 8'h0b;
   localparam logic [7:0] OFS_SECOND_DIV = 8'h0c;
   localparam logic [7:0] OFS_OSR_HI     = 8'h0d;
   localparam logic [7:0] OFS_OSR_LO     = 8'h0e;
   localparam logic [7:0] OFS_GP_SOURCE  = 8'h19;
   localparam logic [7:0] OFS_GP_DIV     = 8'h1a;
   localparam logic [7:0] OFS_BCLK_DIR   = 8'h1b;
   localparam logic [7:0] OFS_BDIV_SRC   = 8'h1d;
   localparam logic [7:0] OFS_BCLK_DIV   = 8'h1e;
   localparam logic [7:0] OFS_STATUS     = 8'h25;
   localparam logic [7:0] OFS_GPIO_CTRL  = 8'h33;
   // Field positions
   localparam int POWER_BIT      = 7;
   localparam int BCLK_DIR_BIT   = 3;
   localparam int STATUS_L_BIT   = 7;
   localparam int STATUS_R_BIT   = 3;
   localparam int GPIO_CLKOUT_BIT = 0;
   // Values after reset
   localparam logic [7:0] RST_SOURCE   = 8'h00;
   localparam logic [7:0] RST_PLL_CTRL = 8'h11;
   localparam logic [7:0] RST_PLL_J    = 8'h04;
   localparam logic [7:0] RST_ZERO     = 8'h00;
   localparam logic [7:0] RST_DIV      = 8'h01;
   localparam logic [7:0] RST_OSR_LO   = 8'h80;
   // Timing
   localparam int CLOCK_MHZ          = 250;
   localparam int PLL_LOCK_MS        = 10;
   localparam int PLL_LOCK_CYCLES    = PLL_LOCK_MS * CLOCK_MHZ * 1000;
   localparam int SHUTDOWN_MOD_EDGES = 64;
   localparam int FRAC_SCALE         = 10000;
   typedef enum logic [1:0] {
      SRC_MCLK, SRC_BCLK, SRC_GPIO, SRC_PLL
   } root_source_t;
endpackage : clock_tree_pkg
`default_nettype wire
